// file: inc/demc_map.vh
`ifndef DEMC_MAP_VH
`define DEMC_MAP_VH
// Register offsets
`define DEMC_OFS_WARN      8'h08
`define DEMC_OFS_POS       8'h26
`define DEMC_OFS_VEL       8'h28
`define DEMC_OFS_OPT       8'h2C
`define DEMC_OFS_TUNE      8'h39
`define DEMC_OFS_RATIO     8'h44
`define DEMC_OFS_MODE      8'h4A
`define DEMC_OFS_TARGET    8'h4B
`define DEMC_OFS_ACC       8'h4C
`define DEMC_OFS_VMAX      8'h4D
`define DEMC_OFS_DUTY      8'h4E
`define DEMC_OFS_SAVE      8'h4F
`define DEMC_OFS_LED       8'h50
// Option bit positions
`define DEMC_OPT_DUAL      10
`define DEMC_OPT_INV2      11
// Ratio is 16.16 fixed point
`define DEMC_RATIO_FRAC    16
`define DEMC_RATIO_RST     32'h0001_0000
// Warning bit positions
`define DEMC_WARN_ENA      0
`define DEMC_WARN_SAT      1
`define DEMC_WARN_TUNE     2
// Regulation modes
`define DEMC_MODE_BRAKE    3'h0
`define DEMC_MODE_OPEN     3'h1
`define DEMC_MODE_SPEED    3'h2
`define DEMC_MODE_POS      3'h3
`define DEMC_MODE_FREE     3'h4
// LED colours
`define DEMC_LED_GREEN     2'h1
`define DEMC_LED_YELLOW    2'h2
`define DEMC_LED_RED       2'h3
// Duty thresholds on a 0..65536 scale
`define DEMC_DUTY_FULL     17'h10000
`define DEMC_DUTY_75       17'h0C000
// Velocity window: 1 s at 200 MHz
`define DEMC_CLK_HZ        200000000
`define DEMC_VEL_WIN_S     1
// Self tune: pulses of encoder two to gather
`define DEMC_TUNE_PULSES   32'h0000_0400
`define DEMC_TUNE_LOG2     10
`endif

// file: logic/demc_top.v
`include "demc_map.vh"
module demc_top #(
    parameter VEL_WIN_CYC = `DEMC_CLK_HZ * `DEMC_VEL_WIN_S
) (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RST,
    // Register access port
    input  wire        REG_WR,
    input  wire        REG_RD,
    input  wire [7:0]  REG_ADDR,
    input  wire [31:0] REG_WDATA,
    output reg  [31:0] REG_RDATA,
    // Encoder pins
    input  wire        ENC1_A,
    input  wire        ENC1_B,
    input  wire        ENC2_A,
    input  wire        ENC2_B,
    // Safety enable pin
    input  wire        ENABLE_PIN,
    // Drive outputs
    output reg  [16:0] PWM_DUTY,
    output reg         PWM_DIR,
    output reg         DRIVE_ON,
    output reg         BRAKE,
    output reg  [1:0]  LED_COLOUR,
    // Nonvolatile save strobe
    output reg         NV_SAVE,
    output reg  [7:0]  NV_ADDR,
    output reg  [31:0] NV_DATA
);
    // Quadrature step: +1, -1 or 0 from old and new AB
    function [1:0] qstep;
        input [1:0] o;
        input [1:0] n;
        begin
            case ({o, n})
                4'b0001, 4'b0111, 4'b1110, 4'b1000: qstep = 2'b01;
                4'b0010, 4'b1011, 4'b1101, 4'b0100: qstep = 2'b11;
                default: qstep = 2'b00;
            endcase
        end
    endfunction

    // Sign extend a quadrature step to the counter width
    function [31:0] sx2;
        input [1:0] s;
        begin
            sx2 = {{30{s[1]}}, s};
        end
    endfunction

    // Magnitude of a two's complement word
    function [31:0] mag32;
        input [31:0] x;
        begin
            mag32 = x[31] ? (32'h0 - x) : x;
        end
    endfunction

    // Synchronisers, two stages each
    reg [4:0] s1_reg;
    reg [4:0] s2_reg;
    reg [1:0] e1_old_reg;             // Last encoder one state
    reg [1:0] e2_old_reg;             // Last encoder two state
    reg [1:0] warm_reg;               // Cycles since reset, saturates
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            // Enable stage resets high: no false enable-dropped warning
            s1_reg     <= 5'h10;
            s2_reg     <= 5'h10;
            e1_old_reg <= 2'h0;
            e2_old_reg <= 2'h0;
            warm_reg   <= 2'h0;
        end else begin
            s1_reg     <= {ENABLE_PIN, ENC2_B, ENC2_A, ENC1_B, ENC1_A};
            s2_reg     <= s1_reg;
            e1_old_reg <= s2_reg[1:0];
            e2_old_reg <= s2_reg[3:2];
            // Saturating warm-up count
            if (warm_reg != 2'h3)
                warm_reg <= warm_reg + 2'h1;
        end
    end
    wire       ena_s = s2_reg[4];
    // Steps are ignored until both stages hold real pin levels;
    // otherwise an encoder resting at a nonzero state would count once
    wire       warm  = (warm_reg == 2'h3);
    wire [1:0] st1   = warm ? qstep(e1_old_reg, s2_reg[1:0]) : 2'b00;
    wire [1:0] st2r  = warm ? qstep(e2_old_reg, s2_reg[3:2]) : 2'b00;

    // Registers
    reg [31:0] opt_reg;               // Option bits
    reg [31:0] ratio_reg;             // Encoder ratio, 16.16
    reg [2:0]  mode_reg;              // Regulation mode
    reg [2:0]  warn_reg;              // Latched warnings
    reg [31:0] target_reg;            // Position target
    reg [31:0] acc_reg;               // Velocity step per tick
    reg [31:0] vmax_reg;              // Top velocity
    reg [16:0] duty_reg;              // Open loop duty
    reg [31:0] pos1_reg;              // Encoder one position
    reg [31:0] pos2_reg;              // Encoder two position
    reg [31:0] vel_cnt_reg;           // Pulses in window
    reg [31:0] vel_reg;               // Pulses per second
    reg [31:0] win_reg;               // Window counter
    reg [31:0] sp_reg;                // Velocity setpoint
    reg        tune_reg;              // Self tune running
    reg [31:0] t1_reg;                // Tune encoder one count
    reg [31:0] t2_reg;                // Tune encoder two count
    reg [3:0]  save_idx_reg;          // Save walk index
    reg        saving_reg;            // Save walk busy

    wire dual = opt_reg[`DEMC_OPT_DUAL];
    wire [1:0] st2 = opt_reg[`DEMC_OPT_INV2] ? (~st2r + 2'b01) : st2r;

    // position from encoder two in dual mode
    wire [31:0] pos_fb = dual ? pos2_reg : pos1_reg;
    wire [31:0] err    = target_reg - pos_fb;
    wire        neg    = err[31];
    wire [31:0] aerr   = mag32(err);
    wire [31:0] vmag   = mag32(sp_reg);
    // Decel once v*v reaches 2*a*distance, the stopping point of a steady ramp;
    // products stay 64 bits wide so large targets cannot wrap the test
    wire [63:0] stopd  = {32'h0, vmag} * {32'h0, vmag};
    wire [63:0] dlim   = {32'h0, aerr} * {31'h0, acc_reg, 1'b0};
    // decel setpoint scaled by ratio onto encoder one
    wire [63:0] sc_ext = {32'h0, aerr} * {32'h0, ratio_reg};
    wire [31:0] scaled = dual ? sc_ext[`DEMC_RATIO_FRAC+31:`DEMC_RATIO_FRAC] : aerr;
    wire        decel  = (stopd >= dlim);

    // Register writes and core state
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            opt_reg      <= 32'h0;
            ratio_reg    <= `DEMC_RATIO_RST;
            mode_reg     <= `DEMC_MODE_BRAKE;
            warn_reg     <= 3'h0;
            target_reg   <= 32'h0;
            acc_reg      <= 32'h1;
            vmax_reg     <= 32'h0;
            duty_reg     <= 17'h0;
            pos1_reg     <= 32'h0;
            pos2_reg     <= 32'h0;
            vel_cnt_reg  <= 32'h0;
            vel_reg      <= 32'h0;
            win_reg      <= 32'h0;
            sp_reg       <= 32'h0;
            tune_reg     <= 1'b0;
            t1_reg       <= 32'h0;
            t2_reg       <= 32'h0;
            save_idx_reg <= 4'h0;
            saving_reg   <= 1'b0;
        end else begin
            // Encoder accumulation
            pos1_reg <= pos1_reg + sx2(st1);
            pos2_reg <= pos2_reg + sx2(st2);
            // velocity counted on encoder one over 1 s
            if (win_reg == VEL_WIN_CYC - 1) begin
                win_reg     <= 32'h0;
                vel_reg     <= vel_cnt_reg + sx2(st1);
                vel_cnt_reg <= 32'h0;
            end else begin
                win_reg     <= win_reg + 32'h1;
                vel_cnt_reg <= vel_cnt_reg + sx2(st1);
            end
            // accel and top phase on encoder one setpoint
            if (mode_reg == `DEMC_MODE_POS) begin
                if (decel) begin
                    sp_reg <= neg ? (32'h0 - scaled) : scaled;
                end else if (vmag < vmax_reg) begin
                    sp_reg <= neg ? (sp_reg - acc_reg) : (sp_reg + acc_reg);
                end
            end else begin
                sp_reg <= 32'h0;
            end
            // self tune gathers pulses on both encoders
            if (tune_reg) begin
                t1_reg <= t1_reg + {31'h0, st1[0]};
                t2_reg <= t2_reg + {31'h0, st2[0]};
                if (t2_reg >= `DEMC_TUNE_PULSES) begin
                    tune_reg  <= 1'b0;
                    // ratio = enc1 change / enc2 change
                    ratio_reg <= t1_reg << (`DEMC_RATIO_FRAC - `DEMC_TUNE_LOG2);
                end
            end
            // Register writes
            if (REG_WR) begin
                case (REG_ADDR)
                    `DEMC_OFS_WARN:   warn_reg <= warn_reg & ~REG_WDATA[2:0];
                    `DEMC_OFS_POS:    pos2_reg <= REG_WDATA;
                    `DEMC_OFS_OPT:    opt_reg <= REG_WDATA;
                    // host may set ratio by hand
                    `DEMC_OFS_RATIO:  ratio_reg <= REG_WDATA;
                    // host rewrites mode to leave brake
                    `DEMC_OFS_MODE:   mode_reg <= REG_WDATA[2:0];
                    `DEMC_OFS_TARGET: target_reg <= REG_WDATA;
                    `DEMC_OFS_ACC:    acc_reg <= REG_WDATA;
                    `DEMC_OFS_VMAX:   vmax_reg <= REG_WDATA;
                    `DEMC_OFS_DUTY:   duty_reg <= REG_WDATA[16:0];
                    `DEMC_OFS_TUNE: begin
                        if (dual) begin
                            tune_reg <= 1'b1;
                            t1_reg   <= 32'h0;
                            t2_reg   <= 32'h0;
                        end
                    end
                    `DEMC_OFS_SAVE: begin
                        saving_reg   <= 1'b1;
                        save_idx_reg <= 4'h0;
                    end
                    default: ;
                endcase
            end
            // enable low forces brake (wins over writes)
            if (!ena_s)
                mode_reg <= `DEMC_MODE_BRAKE;
            if (!ena_s)
                warn_reg[`DEMC_WARN_ENA] <= 1'b1;
            if (PWM_DUTY >= `DEMC_DUTY_FULL)
                warn_reg[`DEMC_WARN_SAT] <= 1'b1;
            if (REG_WR && REG_ADDR == `DEMC_OFS_TUNE && !dual)
                warn_reg[`DEMC_WARN_TUNE] <= 1'b1;
            // save walk, one register per cycle
            if (saving_reg) begin
                save_idx_reg <= save_idx_reg + 4'h1;
                if (save_idx_reg == 4'h6)
                    saving_reg <= 1'b0;
            end
        end
    end

    // Save walk output mux
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            NV_SAVE <= 1'b0;
            NV_ADDR <= 8'h00;
            NV_DATA <= 32'h0;
        end else begin
            NV_SAVE <= saving_reg;
            case (save_idx_reg)
                4'h0: begin NV_ADDR <= `DEMC_OFS_OPT;    NV_DATA <= opt_reg;    end
                4'h1: begin NV_ADDR <= `DEMC_OFS_RATIO;  NV_DATA <= ratio_reg;  end
                4'h2: begin NV_ADDR <= `DEMC_OFS_TARGET; NV_DATA <= target_reg; end
                4'h3: begin NV_ADDR <= `DEMC_OFS_ACC;    NV_DATA <= acc_reg;    end
                4'h4: begin NV_ADDR <= `DEMC_OFS_VMAX;   NV_DATA <= vmax_reg;   end
                4'h5: begin NV_ADDR <= `DEMC_OFS_DUTY;   NV_DATA <= {15'h0, duty_reg}; end
                default: begin NV_ADDR <= `DEMC_OFS_MODE; NV_DATA <= {29'h0, mode_reg}; end
            endcase
        end
    end

    // Drive stage and LED
    wire [31:0] spm = mag32(sp_reg);
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PWM_DUTY   <= 17'h0;
            PWM_DIR    <= 1'b0;
            DRIVE_ON   <= 1'b0;
            BRAKE      <= 1'b1;
            LED_COLOUR <= `DEMC_LED_GREEN;
        end else begin
            DRIVE_ON <= ena_s && mode_reg != `DEMC_MODE_BRAKE && mode_reg != `DEMC_MODE_FREE;
            BRAKE    <= !ena_s || mode_reg == `DEMC_MODE_BRAKE;
            case (mode_reg)
                `DEMC_MODE_OPEN: begin PWM_DUTY <= duty_reg; PWM_DIR <= 1'b0; end
                `DEMC_MODE_POS: begin
                    PWM_DUTY <= (spm > {15'h0, `DEMC_DUTY_FULL}) ? `DEMC_DUTY_FULL : spm[16:0];
                    PWM_DIR  <= sp_reg[31];
                end
                default: begin PWM_DUTY <= 17'h0; PWM_DIR <= 1'b0; end
            endcase
            if (PWM_DUTY >= `DEMC_DUTY_FULL)
                LED_COLOUR <= `DEMC_LED_RED;
            else if (PWM_DUTY > `DEMC_DUTY_75)
                LED_COLOUR <= `DEMC_LED_YELLOW;
            else
                LED_COLOUR <= `DEMC_LED_GREEN;
        end
    end

    // Read mux, registered
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `DEMC_OFS_WARN:   REG_RDATA <= {29'h0, warn_reg};
                `DEMC_OFS_POS:    REG_RDATA <= pos_fb;
                `DEMC_OFS_VEL:    REG_RDATA <= vel_reg;
                `DEMC_OFS_OPT:    REG_RDATA <= opt_reg;
                `DEMC_OFS_RATIO:  REG_RDATA <= ratio_reg;
                `DEMC_OFS_MODE:   REG_RDATA <= {29'h0, mode_reg};
                `DEMC_OFS_TARGET: REG_RDATA <= target_reg;
                `DEMC_OFS_ACC:    REG_RDATA <= acc_reg;
                `DEMC_OFS_VMAX:   REG_RDATA <= vmax_reg;
                `DEMC_OFS_DUTY:   REG_RDATA <= {15'h0, duty_reg};
                `DEMC_OFS_LED:    REG_RDATA <= {30'h0, LED_COLOUR};
                default:          REG_RDATA <= 32'h0;
            endcase
        end
    end
endmodule // demc_top

// file: test/demc_checker.sv
module demc_checker #(
    parameter VEL_WIN_CYC = 100
) (
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST,
    // Register access port
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_RDATA,
    // Pins and drive outputs
    input wire logic        ENABLE_PIN,
    input wire logic [16:0] PWM_DUTY,
    input wire logic        DRIVE_ON,
    input wire logic        BRAKE,
    input wire logic [1:0]  LED_COLOUR,
    input wire logic        NV_SAVE
);
    timeunit 1ns;
    timeprecision 1ps;
    // Single clock domain, reset gates every check
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    // Colour follows a settled duty; the LED is registered, so allow it to settle
    led_green_a: assert property ($stable(PWM_DUTY) [*3] ##0 PWM_DUTY <= 17'h0C000 |-> LED_COLOUR == 2'h1) else $error("LED not green");
    led_yellow_a: assert property ($stable(PWM_DUTY) [*3] ##0 (PWM_DUTY > 17'h0C000 && PWM_DUTY < 17'h10000) |-> LED_COLOUR == 2'h2) else $error("LED not yellow");
    led_red_a: assert property ($stable(PWM_DUTY) [*3] ##0 PWM_DUTY == 17'h10000 |-> LED_COLOUR == 2'h3) else $error("LED not red");
    drive_brake_a: assert property (DRIVE_ON |-> !BRAKE) else $error("Drive and brake together");
    // Two sync flops plus the output register
    enable_low_a: assert property (!ENABLE_PIN [*4] |-> BRAKE && !DRIVE_ON) else $error("Drive kept with enable low");
    brake_hold_a: assert property (BRAKE && !(REG_WR && REG_ADDR == 8'h4A) && !$past(REG_WR && REG_ADDR == 8'h4A) && !$past(REG_WR && REG_ADDR == 8'h4A, 2) |=> BRAKE) else $error("Brake left without mode write");
    save_len_a: assert property ($rose(NV_SAVE) |-> NV_SAVE [*7] ##1 !NV_SAVE) else $error("Save train length wrong");
    save_cause_a: assert property (REG_WR && REG_ADDR == 8'h4F |-> ##[1:3] NV_SAVE) else $error("Save command ignored");
    unmapped_read_a: assert property (REG_RD && REG_ADDR > 8'h50 |=> REG_RDATA == 32'h0) else $error("Unmapped read not zero");
endmodule // demc_checker

bind demc_top demc_checker #(.VEL_WIN_CYC(VEL_WIN_CYC)) chk (.CORE_CLK(CORE_CLK), .RST(RST),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
    .ENABLE_PIN(ENABLE_PIN), .PWM_DUTY(PWM_DUTY), .DRIVE_ON(DRIVE_ON), .BRAKE(BRAKE),
    .LED_COLOUR(LED_COLOUR), .NV_SAVE(NV_SAVE));

// file: test/demc_host.sv
module demc_host (
    // Clock
    input  wire logic   clk,
    // Register requests
    output logic        wr,
    output logic        rd,
    output logic [7:0]  addr,
    output logic [31:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial {wr, rd, addr, wdata} = 42'h0;
    // One access: held through the taking edge, then lines scrambled
    // host reads or writes any one register
    task access(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
endmodule // demc_host

// file: test/demc_bench.sv
module demc_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset, pins
    logic        clk, rst, ena, dir;
    logic        rd_d = 1'b0;
    logic [1:0]  q1, q2;
    logic        wr, rd;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v, p1, r;
    logic [16:0] duty;
    logic        drive_on, brake, nv_save;
    logic [7:0]  nv_addr;
    logic [31:0] nv_data;
    logic [1:0]  led;
    logic [16:0] duty_tab [5] = '{17'h0, 17'h0C000, 17'h0C001, 17'h10000, 17'h08000};
    logic [1:0]  led_tab [5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1};
    logic [31:0] exp_q [$];
    int          error_cnt, comparisons, cyc, n;
    demc_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
    demc_top #(.VEL_WIN_CYC(100)) uut (.CORE_CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .ENC1_A(q1[1]),
        .ENC1_B(q1[1] ^ q1[0]), .ENC2_A(q2[1]), .ENC2_B(q2[1] ^ q2[0]), .ENABLE_PIN(ena),
        .PWM_DUTY(duty), .PWM_DIR(dir), .DRIVE_ON(drive_on), .BRAKE(brake), .LED_COLOUR(led),
        .NV_SAVE(nv_save), .NV_ADDR(nv_addr), .NV_DATA(nv_data));
    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("Compared %0d, mismatched %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        host.access(1'b1, a, d);
    endtask
    // Read whose expectation waits in the queue
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 32'h0);
    endtask
    task rd_now(input logic [7:0] a);
        host.access(1'b0, a, 32'h0);
        @(posedge clk);
        #1 v = rdata;
    endtask
    // Quadrature steps, slow enough for the pin synchronisers
    task automatic step(input logic two, input int k);
        repeat (k) begin
            @(posedge clk);
            if (two) q2 <= q2 + 2'h1;
            else q1 <= q1 + 2'h1;
            repeat (4) @(posedge clk);
        end
    endtask
    // Read monitor and hang guard
    always @(posedge clk) begin
        if (rd_d && exp_q.size() > 0) check(rdata, exp_q.pop_front());
        rd_d <= rd;
        if (++cyc == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        {rst, ena, q1, q2} = 6'h30;
        void'($urandom(32'ha01525e4));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        check({brake, drive_on, led}, 4'h9);
        r = {$urandom} & 32'h00FF_FFFF;
        rd_reg(8'h44, 32'h0001_0000);
        rd_reg(8'h7F, 32'h0);
        wr_reg(8'h44, r);
        rd_reg(8'h44, r);
        wr_reg(8'h2C, 32'h400);
        rd_reg(8'h2C, 32'h400);
        $display("Register map done");
        wr_reg(8'h2C, 32'h0);
        wr_reg(8'h08, 32'h7);
        wr_reg(8'h39, 32'h1);
        rd_reg(8'h08, 32'h4);
        wr_reg(8'h08, 32'h4);
        rd_reg(8'h08, 32'h0);
        $display("Refused tune done");
        step(1'b0, 12);
        rd_now(8'h26);
        check(v[31] ? -v : v, 32'd12);
        wr_reg(8'h2C, 32'h400);
        wr_reg(8'h26, 32'h0);
        step(1'b0, 12);
        step(1'b1, 20);
        rd_now(8'h26);
        p1 = v;
        check(p1[31] ? -p1 : p1, 32'd20);
        wr_reg(8'h26, 32'h0);
        wr_reg(8'h2C, 32'hC00);
        step(1'b1, 20);
        rd_reg(8'h26, -p1);
        $display("Encoder feedback done");
        // Steady stepping gives 20 pulses in each 100-cycle window
        fork
            step(1'b0, 60);
            begin
                repeat (250) @(posedge clk);
                rd_reg(8'h28, 32'hFFFF_FFEC);
            end
        join
        $display("Velocity done");
        // Both encoders step together, so the estimate is unity
        wr_reg(8'h39, 32'h1);
        fork
            step(1'b0, 1024);
            step(1'b1, 1024);
        join
        rd_reg(8'h44, 32'h0001_0000);
        $display("Self tune done");
        // Target below the output position drives backwards
        wr_reg(8'h26, 32'h0);
        wr_reg(8'h4D, 32'h100);
        wr_reg(8'h4B, 32'hFFFF_F000);
        wr_reg(8'h4A, 32'h3);
        repeat (200) @(posedge clk);
        check({dir, duty != 17'h0, drive_on}, 3'h7);
        $display("Position move done");
        wr_reg(8'h4A, 32'h1);
        for (n = 0; n < 5; n++) begin
            wr_reg(8'h4E, {15'h0, duty_tab[n]});
            repeat (8) @(posedge clk);
            check({30'h0, led}, {30'h0, led_tab[n]});
        end
        check({brake, drive_on}, 2'h1);
        $display("Duty colours done");
        wr_reg(8'h08, 32'h7);
        @(posedge clk) ena <= 1'b0;
        repeat (8) @(posedge clk);
        check({brake, drive_on}, 2'h2);
        rd_reg(8'h4A, 32'h0);
        rd_reg(8'h08, 32'h1);
        @(posedge clk) ena <= 1'b1;
        repeat (8) @(posedge clk);
        check({brake, drive_on}, 2'h2);
        wr_reg(8'h4A, 32'h1);
        repeat (4) @(posedge clk);
        check({brake, drive_on}, 2'h1);
        $display("Enable recovery done");
        wr_reg(8'h4F, 32'h1);
        n = 0;
        repeat (20) begin
            @(posedge clk);
            #1 n += nv_save;
            if (nv_save && n == 1) check({nv_addr, nv_data[23:0]}, 32'h2C00_0C00);
        end
        check(n, 32'd7);
        $display("Save done");
        repeat (4) @(posedge clk);
        end_of_test();
    end
endmodule // demc_bench
